/* core/mss_start_sequencer.sv */
// Overview of operation
// - Power-on state after power-up or wake.
// - Speed check enabled goes to detection.
// - Slow speed means stationary, else direction.
// - Forward resynchronizes; reverse compares reverse speed.
// - Fast reverse coasts back to detection.
// - Reverse drive if enabled, else brake decision.
// - Drive forward until zero, then accelerate.
// - Nonzero brake duration enables braking.
// - Brake turns on all low sides.
// - Brake timed, then probe enable decision.
// - Nonzero probe limit probes, else align.
// - Align drives V into W, timed.
// - Probe done goes to accelerate.
// - Accelerate until rate passes handoff threshold.
// - Direction pin change restarts from power-on.
// - Detection keeps phases floating, watches comparators.
// - UW lag forward, UW lead reverse.
// - Speed is interval between rising edges.
// - No toggle within threshold means stationary.
// - Resync loads drive state from measurement.
// - Probe pairs in order, cut at limit.
// - Shortest probe time gives rotor position.
// - Start drive offset by advance angle.
`timescale 1ns/1ns
`default_nettype none
module mss_start_sequencer
   import mss_pkg::*;
#(
   parameter int unsigned UNIT_CYC = mss_pkg::TIME_UNIT_CYC,
   parameter int unsigned TICK_CYC = mss_pkg::ACCEL_TICK_CYC,
   parameter int unsigned PROBE_MAX = mss_pkg::PROBE_MAX_CYC,
   parameter int unsigned PROBE_GAP = mss_pkg::PROBE_GAP_CYC
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Power management and direction
   input wire logic wake_event,
   input wire logic direction_pin,
   // Configuration
   input wire logic initial_speed_check_enable,
   input wire logic [1:0] stationary_speed_threshold,
   input wire logic [1:0] reverse_speed_limit,
   input wire logic reverse_drive_enable,
   input wire logic [2:0] brake_duration,
   input wire logic [3:0] position_probe_current_limit,
   input wire logic [2:0] alignment_duration,
   input wire logic [1:0] open_loop_current,
   input wire logic [2:0] first_order_accel_rate,
   input wire logic [2:0] second_order_accel_rate,
   input wire logic [4:0] handoff_speed_threshold,
   input wire logic [1:0] probe_advance_angle,
   // Motor feedback
   input wire logic cmp_uv,
   input wire logic cmp_uw,
   input wire logic probe_current_reached,
   input wire logic motor_zero_speed,
   // Power stage
   output logic [2:0] high_side_on,
   output logic [2:0] low_side_on,
   output logic phases_floating,
   output logic [1:0] current_limit_sel,
   output logic [3:0] probe_limit_sel,
   // Status and handoff
   output logic [13:0] sequencer_state,
   output logic closed_loop_active,
   output logic resync_load,
   output logic [2:0] drive_step,
   output logic [mss_pkg::CNT_W-1:0] resync_period,
   output logic [mss_pkg::VEL_W-1:0] drive_rate
);
   import mss_pkg::*;

   if (UNIT_CYC < 1 || TICK_CYC < 1 || TICK_CYC > 65536 || PROBE_MAX < 1 || PROBE_GAP < 1)
   begin : g_chk
      $error("bad timing parameters");
   end

   mss_state_t state_q, state_d;
   logic dir_q;
   logic [CNT_W-1:0] tmr_q;
   logic [2:0] step_q;
   logic [VEL_W-1:0] vel_q, acc2_q;
   logic [VEL_W-1:0] phase_q;
   logic [15:0] tick_q;
   logic [2:0] probe_idx_q, probe_min_idx_q;
   logic probe_on_q, probe_done_q;
   logic [CNT_W-1:0] probe_min_q;
   logic resync_q;
   logic [CNT_W-1:0] resync_per_q;
   logic [5:0] gates_q;
   logic float_q;
   logic dir_change;
   logic accel_tick;
   logic probe_flip;

   mss_isd_if isd ();

   mss_speed_detect u_isd (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .cmp_uv(cmp_uv),
      .cmp_uw(cmp_uw),
      .isd(isd)
   );

   // Time limit of a threshold field: (code + 1) base units.
   function automatic logic [CNT_W-1:0] unit_span(input logic [2:0] code);
      return CNT_W'(({29'h0, code} + 32'h1) * UNIT_CYC);
   endfunction

   assign dir_change = direction_pin != dir_q;
   assign accel_tick = tick_q == 16'(TICK_CYC - 1);
   // Timer restarts at each pulse cut and at each pulse start.
   assign probe_flip = state_q == MSS_PROBE && (probe_on_q ?
      (probe_current_reached || tmr_q >= CNT_W'(PROBE_MAX)) :
      (tmr_q >= CNT_W'(PROBE_GAP) && !probe_done_q));

   // ==========================================================================
   // Sequencer state
   // ==========================================================================
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         MSS_POWER_ON:
            state_d = initial_speed_check_enable ? MSS_SPEED_DET : MSS_BRK_EN;
         MSS_SPEED_DET:
            if (isd.done)
            begin
               state_d = MSS_SPEED_JUDG;
            end
         MSS_SPEED_JUDG:
            if (isd.stationary || isd.period > unit_span({1'b0, stationary_speed_threshold}))
            begin
               state_d = MSS_BRK_EN;
            end
            else
            begin
               state_d = MSS_FWD_JUDG;
            end
         MSS_FWD_JUDG:
            state_d = isd.forward ? MSS_CLOSED : MSS_REV_JUDG;
         MSS_REV_JUDG:
            // too fast in reverse, coast and retry
            if (isd.period < unit_span({1'b0, reverse_speed_limit}))
            begin
               state_d = MSS_SPEED_DET;
            end
            else
            begin
               state_d = MSS_RVS_EN;
            end
         MSS_RVS_EN:
            state_d = reverse_drive_enable ? MSS_RVS_DRIVE : MSS_BRK_EN;
         MSS_RVS_DRIVE:
            if (motor_zero_speed)
            begin
               state_d = MSS_ACCEL;
            end
         MSS_BRK_EN:
            state_d = (brake_duration != 3'h0) ? MSS_BRAKE : MSS_PROBE_EN;
         MSS_BRAKE:
            if (tmr_q >= unit_span(brake_duration))
            begin
               state_d = MSS_PROBE_EN;
            end
         MSS_PROBE_EN:
            state_d = (position_probe_current_limit != 4'h0) ? MSS_PROBE : MSS_ALIGN;
         MSS_ALIGN:
            if (tmr_q >= unit_span(alignment_duration))
            begin
               state_d = MSS_ACCEL;
            end
         MSS_PROBE:
            if (probe_done_q)
            begin
               state_d = MSS_ACCEL;
            end
         MSS_ACCEL:
            if (vel_q[VEL_W-1:VEL_FRAC] > {5'h0, handoff_speed_threshold})
            begin
               state_d = MSS_CLOSED;
            end
         MSS_CLOSED:
            state_d = MSS_CLOSED;
         default:
            state_d = MSS_POWER_ON;
      endcase
      if (dir_change)
      begin
         state_d = MSS_POWER_ON;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || wake_event)
      begin
         state_q <= MSS_POWER_ON;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      dir_q <= sys_rst ? 1'b0 : direction_pin;
      if (sys_rst || state_d != state_q || probe_flip)
      begin
         tmr_q <= '0;
      end
      else
      begin
         tmr_q <= tmr_q + 1'b1;
      end
   end

   assign isd.start = state_q != MSS_SPEED_DET && state_d == MSS_SPEED_DET;
   assign isd.timeout_cyc = unit_span({1'b0, stationary_speed_threshold});

   // ==========================================================================
   // Inductive position probe
   // ==========================================================================
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || state_q != MSS_PROBE)
      begin
         probe_idx_q <= 3'h0;
         probe_on_q <= 1'b1;
         probe_done_q <= 1'b0;
         probe_min_q <= '1;
         probe_min_idx_q <= 3'h0;
      end
      else if (probe_on_q)
      begin
         // cut pulse at current limit, record time
         if (probe_current_reached || tmr_q >= CNT_W'(PROBE_MAX))
         begin
            probe_on_q <= 1'b0;
            if (tmr_q < probe_min_q)
            begin
               probe_min_q <= tmr_q;
               probe_min_idx_q <= probe_idx_q;
            end
         end
      end
      else if (tmr_q >= CNT_W'(PROBE_GAP) && !probe_done_q)
      begin
         if (probe_idx_q == 3'(NUM_STEPS - 1))
         begin
            probe_done_q <= 1'b1;
         end
         else
         begin
            probe_idx_q <= probe_idx_q + 3'h1;
            probe_on_q <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Open-loop acceleration and commutation
   // ==========================================================================
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || state_q != MSS_ACCEL)
      begin
         tick_q <= 16'h0;
      end
      else
      begin
         tick_q <= accel_tick ? 16'h0 : tick_q + 16'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || state_q != MSS_ACCEL)
      begin
         vel_q <= '0;
         acc2_q <= '0;
      end
      else if (accel_tick)
      begin
         acc2_q <= acc2_q + VEL_W'(second_order_accel_rate);
         vel_q <= vel_q + VEL_W'(first_order_accel_rate) + acc2_q;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      resync_q <= 1'b0;
      if (sys_rst || state_q == MSS_POWER_ON)
      begin
         step_q <= STEP_RST;
         phase_q <= '0;
         resync_per_q <= '0;
      end
      else if (state_q == MSS_FWD_JUDG && isd.forward)
      begin
         step_q <= isd.position;
         resync_per_q <= isd.period;
         resync_q <= 1'b1;
      end
      else if (state_q == MSS_RVS_EN)
      begin
         // drive ahead of rotor to brake it
         step_q <= mss_step_add(isd.position, 3'h3);
      end
      else if (state_q == MSS_PROBE && probe_done_q)
      begin
         step_q <= mss_step_add(probe_min_idx_q, {1'b0, probe_advance_angle});
      end
      else if (state_q == MSS_ALIGN)
      begin
         step_q <= ALIGN_STEP;
      end
      else if (state_q == MSS_ACCEL)
      begin
         {phase_q} <= phase_q + vel_q;
         if (phase_q + vel_q < phase_q)
         begin
            step_q <= mss_step_add(step_q, 3'h1);
         end
      end
   end

   // ==========================================================================
   // Gate drive
   // ==========================================================================
   always_ff @(posedge sys_clk)
   begin
      gates_q <= 6'h00;
      float_q <= 1'b1;
      if (!sys_rst && !dir_change)
      begin
         case (state_q)
            MSS_BRAKE:
            begin
               gates_q <= 6'h07;
               float_q <= 1'b0;
            end
            MSS_ALIGN:
            begin
               // current into V, out of W
               gates_q <= mss_step_gates(ALIGN_STEP);
               float_q <= 1'b0;
            end
            MSS_PROBE:
            begin
               // pair order VW WV UV VU WU UW
               gates_q <= probe_on_q ? mss_step_gates(probe_idx_q) : 6'h00;
               float_q <= !probe_on_q;
            end
            MSS_RVS_DRIVE, MSS_ACCEL, MSS_CLOSED:
            begin
               gates_q <= mss_step_gates(step_q);
               float_q <= 1'b0;
            end
            default:
            begin
               gates_q <= 6'h00;
               float_q <= 1'b1;
            end
         endcase
      end
   end

   assign high_side_on = gates_q[5:3];
   assign low_side_on = gates_q[2:0];
   assign phases_floating = float_q;
   assign current_limit_sel = open_loop_current;
   assign probe_limit_sel = position_probe_current_limit;
   assign sequencer_state = state_q;
   assign closed_loop_active = state_q == MSS_CLOSED;
   assign resync_load = resync_q;
   assign drive_step = step_q;
   assign resync_period = resync_per_q;
   assign drive_rate = vel_q;

endmodule // mss_start_sequencer
`default_nettype wire

/* core/mss_pkg.sv */
package mss_pkg;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned CLK_MHZ = 125;
   // Brake, align and stationary time unit in ms.
   localparam int unsigned TIME_UNIT_MS = 10;
   localparam int unsigned TIME_UNIT_CYC = TIME_UNIT_MS * 1000 * CLK_MHZ;
   // Acceleration update interval in us.
   localparam int unsigned ACCEL_TICK_US = 100;
   localparam int unsigned ACCEL_TICK_CYC = ACCEL_TICK_US * CLK_MHZ;
   // Probe pulse limit and settle gap in us.
   localparam int unsigned PROBE_MAX_US = 200;
   localparam int unsigned PROBE_MAX_CYC = PROBE_MAX_US * CLK_MHZ;
   localparam int unsigned PROBE_GAP_US = 20;
   localparam int unsigned PROBE_GAP_CYC = PROBE_GAP_US * CLK_MHZ;

   // ==========================================================================
   // Widths and reset values
   // ==========================================================================
   localparam int unsigned CNT_W = 32;
   localparam int unsigned VEL_W = 24;
   localparam int unsigned VEL_FRAC = 14;
   localparam int unsigned NUM_STEPS = 6;
   localparam logic [2:0] STEP_RST = 3'h0;
   // Probe order VW, WV, UV, VU, WU, UW; index 0 is also the align pattern.
   localparam logic [2:0] ALIGN_STEP = 3'h0;

   typedef enum logic [13:0] {
      MSS_POWER_ON   = 14'h0001,
      MSS_SPEED_DET  = 14'h0002,
      MSS_SPEED_JUDG = 14'h0004,
      MSS_FWD_JUDG   = 14'h0008,
      MSS_REV_JUDG   = 14'h0010,
      MSS_RVS_EN     = 14'h0020,
      MSS_RVS_DRIVE  = 14'h0040,
      MSS_BRK_EN     = 14'h0080,
      MSS_BRAKE      = 14'h0100,
      MSS_PROBE_EN   = 14'h0200,
      MSS_ALIGN      = 14'h0400,
      MSS_PROBE      = 14'h0800,
      MSS_ACCEL      = 14'h1000,
      MSS_CLOSED     = 14'h2000
   } mss_state_t;

   // High-side (bits 5:3, U V W) and low-side (bits 2:0, U V W) gate pattern of a step.
   function automatic logic [5:0] mss_step_gates(input logic [2:0] step);
      logic [5:0] g;
      g = 6'h00;
      case (step)
         3'h0: g = 6'h11;
         3'h1: g = 6'h0A;
         3'h2: g = 6'h22;
         3'h3: g = 6'h14;
         3'h4: g = 6'h0C;
         3'h5: g = 6'h21;
         default: g = 6'h00;
      endcase
      return g;
   endfunction

   // Advance a step index by n with wrap at six.
   function automatic logic [2:0] mss_step_add(input logic [2:0] step, input logic [2:0] n);
      logic [3:0] s;
      s = {1'b0, step} + {1'b0, n};
      if (s >= 4'h6)
      begin
         s = s - 4'h6;
      end
      return s[2:0];
   endfunction

endpackage

/* core/mss_isd_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Carries the speed-detect request and its result between sequencer and detector.
interface mss_isd_if;
   logic start;
   logic done;
   logic stationary;
   logic forward;
   logic [mss_pkg::CNT_W-1:0] period;
   logic [2:0] position;
   logic [mss_pkg::CNT_W-1:0] timeout_cyc;

   modport seq (output start, output timeout_cyc, input done, input stationary,
                input forward, input period, input position);
   modport det (input start, input timeout_cyc, output done, output stationary,
                output forward, output period, output position);
endinterface
`default_nettype wire

/* core/mss_speed_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module mss_speed_detect
   import mss_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Phase-to-phase comparators
   input wire logic cmp_uv,
   input wire logic cmp_uw,
   // Sequencer side
   mss_isd_if.det isd
);

   logic uv_q, uw_q;
   logic active_q, seen_q;
   logic [CNT_W-1:0] cnt_q, rise_cnt_q;
   logic done_q, stat_q, fwd_q;
   logic [CNT_W-1:0] period_q;
   logic [2:0] pos_q;
   logic rise_uv, rise_uw, any_edge;

   assign rise_uv = cmp_uv && !uv_q;
   assign rise_uw = cmp_uw && !uw_q;
   assign any_edge = (cmp_uv != uv_q) || (cmp_uw != uw_q);

   always_ff @(posedge sys_clk)
   begin
      uv_q <= sys_rst ? 1'b0 : cmp_uv;
      uw_q <= sys_rst ? 1'b0 : cmp_uw;
   end

   // ==========================================================================
   // Measurement
   // ==========================================================================
   always_ff @(posedge sys_clk)
   begin
      done_q <= 1'b0;
      if (sys_rst)
      begin
         active_q <= 1'b0;
         seen_q <= 1'b0;
         cnt_q <= '0;
         stat_q <= 1'b0;
         fwd_q <= 1'b0;
         period_q <= '0;
         pos_q <= STEP_RST;
         rise_cnt_q <= '0;
      end
      else if (isd.start)
      begin
         active_q <= 1'b1;
         rise_cnt_q <= '0;
         seen_q <= 1'b0;
         cnt_q <= '0;
      end
      else if (active_q)
      begin
         cnt_q <= any_edge ? '0 : cnt_q + 1'b1;
         rise_cnt_q <= (rise_uv || rise_uw) ? '0 : rise_cnt_q + 1'b1;
         if (!any_edge && cnt_q >= isd.timeout_cyc)
         begin
            active_q <= 1'b0;
            done_q <= 1'b1;
            stat_q <= 1'b1;
         end
         else if (rise_uv || rise_uw)
         begin
            seen_q <= 1'b1;
            if (rise_uv)
            begin
               // UW low at UV rise means UW lags
               fwd_q <= !cmp_uw;
            end
            pos_q <= {1'b0, cmp_uv, cmp_uw};
            if (seen_q && rise_uv)
            begin
               period_q <= rise_cnt_q + 1'b1;
               active_q <= 1'b0;
               done_q <= 1'b1;
               stat_q <= 1'b0;
            end
         end
      end
   end

   assign isd.done = done_q;
   assign isd.stationary = stat_q;
   assign isd.forward = fwd_q;
   assign isd.period = period_q;
   assign isd.position = pos_q;

endmodule // mss_speed_detect
`default_nettype wire

/* bench/mss_seq_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module mss_seq_properties
   import mss_pkg::*;
#(
   parameter int unsigned UNIT_CYC = 20
)
(
   // Clock, reset and controls
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wake_event,
   input wire logic direction_pin,
   // Configuration
   input wire logic initial_speed_check_enable,
   input wire logic reverse_drive_enable,
   input wire logic [2:0] brake_duration,
   input wire logic [3:0] position_probe_current_limit,
   // Observed outputs
   input wire logic [2:0] high_side_on,
   input wire logic [2:0] low_side_on,
   input wire logic phases_floating,
   input wire logic [13:0] sequencer_state
);
   // ==========
   // Helpers.
   logic dir_q;
   logic quiet;
   logic [31:0] brk_cnt;
   logic [31:0] brk_span;
   always_ff @(posedge sys_clk)
   begin
      dir_q <= direction_pin;
   end
   always_ff @(posedge sys_clk)
   begin
      brk_cnt <= (sys_rst || sequencer_state != MSS_BRAKE) ? 32'h0 : brk_cnt + 32'h1;
   end
   assign quiet = !wake_event && direction_pin == dir_q;
   assign brk_span = (32'(brake_duration) + 32'h1) * UNIT_CYC;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ==========
   // Properties.
   property p_wake;
      wake_event |=> sequencer_state == MSS_POWER_ON;
   endproperty
   a_wake: assert property (p_wake) else $error("no restart after wake");
   property p_dir;
      direction_pin != dir_q |=> sequencer_state == MSS_POWER_ON && high_side_on == 3'h0
         && low_side_on == 3'h0;
   endproperty
   a_dir: assert property (p_dir) else $error("drive kept after direction change");
   property p_power_on;
      sequencer_state == MSS_POWER_ON && quiet |=> sequencer_state ==
         ($past(initial_speed_check_enable) ? MSS_SPEED_DET : MSS_BRK_EN);
   endproperty
   a_power_on: assert property (p_power_on) else $error("wrong exit from power-on");
   property p_brake_en;
      sequencer_state == MSS_BRK_EN && quiet |=> sequencer_state ==
         (($past(brake_duration) != 3'h0) ? MSS_BRAKE : MSS_PROBE_EN);
   endproperty
   a_brake_en: assert property (p_brake_en) else $error("wrong brake decision");
   property p_rev_en;
      sequencer_state == MSS_RVS_EN && quiet |=> sequencer_state ==
         ($past(reverse_drive_enable) ? MSS_RVS_DRIVE : MSS_BRK_EN);
   endproperty
   a_rev_en: assert property (p_rev_en) else $error("wrong reverse decision");
   property p_probe_en;
      sequencer_state == MSS_PROBE_EN && quiet |=> sequencer_state ==
         (($past(position_probe_current_limit) != 4'h0) ? MSS_PROBE : MSS_ALIGN);
   endproperty
   a_probe_en: assert property (p_probe_en) else $error("wrong probe decision");
   property p_brake_gates;
      sequencer_state == MSS_BRAKE && $past(sequencer_state) == MSS_BRAKE |->
         low_side_on == 3'h7 && high_side_on == 3'h0;
   endproperty
   a_brake_gates: assert property (p_brake_gates) else $error("brake gates wrong");
   property p_align_gates;
      sequencer_state == MSS_ALIGN && $past(sequencer_state) == MSS_ALIGN |->
         high_side_on == 3'h2 && low_side_on == 3'h1;
   endproperty
   a_align_gates: assert property (p_align_gates) else $error("align gates wrong");
   property p_float;
      sequencer_state == MSS_SPEED_DET [*2] |-> phases_floating && high_side_on == 3'h0;
   endproperty
   a_float: assert property (p_float) else $error("phases driven in detection");
   property p_brake_time;
      $past(sequencer_state) == MSS_BRAKE && sequencer_state != MSS_BRAKE && $past(quiet)
         |-> brk_cnt + 32'h1 >= brk_span && brk_cnt <= brk_span + 32'h1;
   endproperty
   a_brake_time: assert property (p_brake_time) else $error("brake length wrong");
endmodule // mss_seq_properties
`default_nettype wire

/* bench/mss_motor_model.sv */
`timescale 1ns/1ns
`default_nettype none
module mss_motor_model
(
   // Clock and scenario control
   input wire logic sys_clk,
   input wire logic [1:0] spin,
   input wire logic clear,
   // Gate drive
   input wire logic [2:0] high_side_on,
   input wire logic [2:0] low_side_on,
   // Feedback
   output logic cmp_uv,
   output logic cmp_uw,
   output logic probe_current_reached,
   output logic motor_zero_speed
);
   // ==========
   // Rotor and windings.
   logic [2:0] ph_q = 3'h0;
   logic [4:0] sub_q = 5'h00;
   logic [7:0] on_q = 8'h00;
   logic [7:0] drv_q = 8'h00;
   logic [5:0] pat [6];
   int n_pat = 0;
   // Spin 1 and 3 step a sector every 4 cycles, spin 2 every 24, spin 0 stands.
   always @(posedge sys_clk)
   begin
      if (spin != 2'h0)
      begin
         sub_q <= (sub_q >= ((spin == 2'h2) ? 5'h17 : 5'h03)) ? 5'h00 : sub_q + 5'h01;
         if (sub_q >= ((spin == 2'h2) ? 5'h17 : 5'h03))
         begin
            ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
         end
      end
   end
   assign cmp_uv = ph_q < 3'h3;
   // Forward puts the UW crossing one sector behind UV, reverse one ahead.
   assign cmp_uw = (spin == 2'h1) ? (ph_q >= 3'h1 && ph_q <= 3'h3) : (ph_q <= 3'h1 || ph_q == 3'h5);
   // Current rises fastest on the pair lined up with the rotor.
   assign probe_current_reached = on_q >= (({high_side_on, low_side_on} == 6'h22) ? 8'h03 : 8'h06);
   assign motor_zero_speed = drv_q >= 8'h10;
   always @(posedge sys_clk)
   begin
      on_q <= (high_side_on == 3'h0) ? 8'h00 : on_q + 8'(on_q != 8'hFF);
      drv_q <= clear ? 8'h00 : drv_q + 8'(high_side_on != 3'h0 && drv_q != 8'hFF);
      if (clear)
      begin
         n_pat <= 0;
      end
      else if (high_side_on != 3'h0 && on_q == 8'h00 && n_pat < 6)
      begin
         pat[n_pat] <= {high_side_on, low_side_on};
         n_pat <= n_pat + 1;
      end
   end
endmodule // mss_motor_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mss_pkg::*;
   localparam int unsigned UNIT = 20;
   logic sys_clk, sys_rst, wake_event, direction_pin, initial_speed_check_enable;
   logic reverse_drive_enable, cmp_uv, cmp_uw, probe_current_reached, motor_zero_speed;
   logic phases_floating, closed_loop_active, resync_load;
   logic [1:0] stationary_speed_threshold, reverse_speed_limit, open_loop_current;
   logic [1:0] probe_advance_angle, spin, current_limit_sel;
   logic [2:0] brake_duration, alignment_duration, first_order_accel_rate;
   logic [2:0] second_order_accel_rate, high_side_on, low_side_on, drive_step;
   logic [3:0] position_probe_current_limit, probe_limit_sel;
   logic [4:0] handoff_speed_threshold;
   logic [13:0] sequencer_state;
   logic [CNT_W-1:0] resync_period;
   logic [VEL_W-1:0] drive_rate;
   logic [5:0] exp_pat [6] = '{6'h11, 6'h0A, 6'h22, 6'h14, 6'h0C, 6'h21};
   int failures = 0;
   int total_checks = 0;
   int waited = 0;
   int resyncs = 0;
   mss_start_sequencer #(.UNIT_CYC(UNIT), .TICK_CYC(4), .PROBE_MAX(30), .PROBE_GAP(3)) dut (.*);
   mss_motor_model motor (.*, .clear(wake_event));
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      resyncs <= wake_event ? 0 : resyncs + int'(resync_load === 1'b1);
   end
   // ==========
   // Access tasks.
   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wait_state(input logic [13:0] st, input int bound);
      waited = 0;
      #1;
      while (sequencer_state !== st && waited < bound)
      begin
         @(posedge sys_clk);
         #1;
         waited++;
      end
      total_checks++;
      if (sequencer_state !== st)
      begin
         failures++;
         $display("Error at %0t: state %0h not reached", $time, st);
         conclude();
      end
   endtask
   task automatic start(input logic isd, input logic [2:0] brk, input logic [3:0] prb,
                        input logic ren, input logic [1:0] spn);
      @(posedge sys_clk);
      initial_speed_check_enable <= isd;
      brake_duration <= brk;
      position_probe_current_limit <= prb;
      reverse_drive_enable <= ren;
      spin <= spn;
      wake_event <= 1'b1;
      @(posedge sys_clk);
      wake_event <= 1'b0;
   endtask
   // ==========
   // Scenarios.
   initial
   begin
      sys_rst = 1'b1;
      wake_event = 1'b0;
      direction_pin = 1'b0;
      initial_speed_check_enable = 1'b0;
      stationary_speed_threshold = 2'h3;
      reverse_speed_limit = 2'h0;
      reverse_drive_enable = 1'b0;
      brake_duration = 3'h0;
      position_probe_current_limit = 4'h0;
      alignment_duration = 3'h1;
      open_loop_current = 2'h2;
      first_order_accel_rate = 3'h7;
      second_order_accel_rate = 3'h7;
      handoff_speed_threshold = 5'h01;
      probe_advance_angle = 2'h1;
      spin = 2'h0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      wait_state(MSS_BRK_EN, 3);
      wait_state(MSS_PROBE_EN, 2);
      wait_state(MSS_ALIGN, 2);
      check(current_limit_sel, 2'h2);
      wait_state(MSS_ACCEL, 2 * UNIT + 6);
      check(waited >= 2 * UNIT, 1'b1);
      wait_state(MSS_CLOSED, 20000);
      check(closed_loop_active, 1'b1);
      start(1'b0, 3'h2, 4'h5, 1'b0, 2'h0);
      wait_state(MSS_BRAKE, 3);
      repeat (2) @(posedge sys_clk);
      check(low_side_on, 3'h7);
      wait_state(MSS_PROBE_EN, 3 * UNIT + 6);
      check(waited >= 3 * UNIT - 2, 1'b1);
      wait_state(MSS_PROBE, 2);
      check(probe_limit_sel, 4'h5);
      wait_state(MSS_ACCEL, 600);
      for (int i = 0; i < 6; i++)
      begin
         check(motor.pat[i], exp_pat[i]);
      end
      check(drive_step, 3'h3);
      @(posedge sys_clk);
      direction_pin <= ~direction_pin;
      wait_state(MSS_POWER_ON, 3);
      start(1'b1, 3'h0, 4'h0, 1'b0, 2'h1);
      wait_state(MSS_SPEED_JUDG, 200);
      wait_state(MSS_FWD_JUDG, 2);
      wait_state(MSS_CLOSED, 2);
      repeat (2) @(posedge sys_clk);
      check(resyncs, 1);
      start(1'b1, 3'h0, 4'h0, 1'b1, 2'h2);
      wait_state(MSS_REV_JUDG, 400);
      wait_state(MSS_RVS_EN, 2);
      wait_state(MSS_RVS_DRIVE, 2);
      wait_state(MSS_ACCEL, 100);
      start(1'b1, 3'h0, 4'h0, 1'b0, 2'h3);
      wait_state(MSS_REV_JUDG, 200);
      wait_state(MSS_SPEED_DET, 2);
      @(posedge sys_clk);
      spin <= 2'h2;
      wait_state(MSS_RVS_EN, 800);
      wait_state(MSS_BRK_EN, 2);
      start(1'b1, 3'h0, 4'h0, 1'b0, 2'h0);
      wait_state(MSS_SPEED_JUDG, 4 * UNIT + 8);
      check(waited >= 4 * UNIT - 2, 1'b1);
      wait_state(MSS_BRK_EN, 2);
      conclude();
   end
endmodule // testbench
bind mss_start_sequencer mss_seq_properties #(.UNIT_CYC(UNIT_CYC)) props (.*);
`default_nettype wire
